// file: design/ocpp_channel.v
// Purpose: One output compare channel with single pulse, continuous pulse and PWM modes,
//          plus two simple 16-bit timebases to compare against.
// Assumes: All inputs synchronous to clk; software reaches registers over a plain port.
// Notes:   Timer prescalers are one-cycle enable inputs; irqReq is registered.
//
// Contract
// - Writing mode 100 drives the pin low and arms exactly one pulse.
// - Pulse modes drive the pin high on the primary match.
// - Single mode drives low on secondary match and stays low until re-armed.
// - Single-mode trailing match sets the flag; request only if enabled.
// - Rewriting mode 100 re-arms without stopping or clearing the timer.
// - Mode 101 drives low, then pulses every period between the two matches.
// - Count equal to period resets to zero and counting continues.
// - Continuous mode sets the flag on every secondary match.
// - Channel compares against the timebase chosen by the select bit.
// - In PWM modes software writes to the primary value are ignored.
// - PWM copies secondary into primary only on the period match.
// - The first PWM period uses the primary value already held.
// - Period value N yields a PWM period of N plus one counts.
// - PWM duty zero holds the pin low continuously.
// - PWM duty above period holds the pin high continuously.
// - PWM duty equal to period gives low for exactly one count value.
// - Mode 111 is PWM with fault, 110 PWM without fault, 000 disabled.
// - Select one picks the second timer, zero picks the first.
// - Fault status sets on a PWM fault, cleared only by hardware.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ocpp_consts.vh"

module ocpp_channel
#(
	parameter WIDTH = 16
)
(
	input  wire             clk,        // 125 MHz clock
	input  wire             srst,       // Synchronous reset, active high
	input  wire [2:0]       regAddr,    // Register index
	input  wire [WIDTH-1:0] regWdata,   // Write data
	input  wire             regWr,      // Write strobe
	input  wire             regRd,      // Read strobe
	output reg  [WIDTH-1:0] regRdata,   // Read data, cycle after regRd
	input  wire             tickEn0,    // Prescaled count enable, first timer
	input  wire             tickEn1,    // Prescaled count enable, second timer
	input  wire             faultIn,    // Fault input, active high
	output reg              comparePin, // Compare output pin
	output reg              irqReq      // Interrupt request level
);

	reg  [2:0]       modeReg;
	reg              tbSelReg;
	reg              run0Reg;
	reg              run1Reg;
	reg              irqEnReg;
	reg              irqFlagReg;
	reg              faultReg;
	reg              armedReg;
	reg  [WIDTH-1:0] primaryReg;
	reg  [WIDTH-1:0] secondaryReg;
	reg  [WIDTH-1:0] period0Reg;
	reg  [WIDTH-1:0] period1Reg;
	reg  [WIDTH-1:0] timer0Reg;
	reg  [WIDTH-1:0] timer1Reg;
	reg              pinNext;
	reg              armedNext;
	reg              flagSet;
	reg              faultSet;
	reg  [WIDTH-1:0] rdNext;

	wire             ctrlWr  = regWr && (regAddr == `OCPP_REG_CTRL);
	wire [2:0]       wrMode  = regWdata[`OCPP_CTRL_MODE_HI:`OCPP_CTRL_MODE_LO];
	wire             isPwm   = (modeReg == `OCPP_MODE_PWM) || (modeReg == `OCPP_MODE_PWMFLT);
	// Selected timebase.
	// timebase select.
	wire [WIDTH-1:0] tbCount = tbSelReg ? timer1Reg : timer0Reg;
	wire [WIDTH-1:0] tbPer   = tbSelReg ? period1Reg : period0Reg;
	wire             tbTick  = tbSelReg ? (run1Reg && tickEn1) : (run0Reg && tickEn0);
	wire             perHit  = tbTick && (tbCount == tbPer);
	wire             priHit  = tbCount == primaryReg;
	wire             secHit  = tbCount == secondaryReg;

	// Next count of a free-running timebase with period reset.
	function [WIDTH-1:0] nextCount;
		input [WIDTH-1:0] cnt;
		input [WIDTH-1:0] per;
		begin
			if (cnt == per)
				nextCount = `OCPP_COUNT_ZERO;
			else
				nextCount = cnt + 1'b1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Timebases.
	always @(posedge clk)
	begin
		if (srst)
		begin
			timer0Reg  <= `OCPP_COUNT_ZERO;
			timer1Reg  <= `OCPP_COUNT_ZERO;
			period0Reg <= `OCPP_RESET_PERIOD;
			period1Reg <= `OCPP_RESET_PERIOD;
		end
		else
		begin
			if (regWr && regAddr == `OCPP_REG_TIMER0)
				timer0Reg <= regWdata;
			else if (run0Reg && tickEn0)
				timer0Reg <= nextCount(timer0Reg, period0Reg);
			if (regWr && regAddr == `OCPP_REG_TIMER1)
				timer1Reg <= regWdata;
			else if (run1Reg && tickEn1)
				timer1Reg <= nextCount(timer1Reg, period1Reg);
			if (regWr && regAddr == `OCPP_REG_PERIOD0)
				period0Reg <= regWdata;
			if (regWr && regAddr == `OCPP_REG_PERIOD1)
				period1Reg <= regWdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output pin, arming, flag and fault decisions.
	always @*
	begin
		pinNext   = comparePin;
		armedNext = armedReg;
		flagSet   = 1'b0;
		faultSet  = 1'b0;
		if (ctrlWr)
		begin
			pinNext   = 1'b0;
			armedNext = (wrMode == `OCPP_MODE_SINGLE) || (wrMode == `OCPP_MODE_CONT);
		end
		else if (tbTick)
		begin
			case (modeReg)
				`OCPP_MODE_SINGLE, `OCPP_MODE_CONT:
				begin
					if (armedReg && priHit)
						pinNext = 1'b1;
					if (armedReg && secHit)
					begin
						pinNext = 1'b0;
						flagSet = 1'b1;
						if (modeReg == `OCPP_MODE_SINGLE)
							armedNext = 1'b0;
					end
				end
				`OCPP_MODE_PWM, `OCPP_MODE_PWMFLT:
				begin
					if (primaryReg == `OCPP_COUNT_ZERO)
						pinNext = 1'b0;
					else if (primaryReg > tbPer)
						pinNext = 1'b1;
					else if (tbCount == tbPer)
						pinNext = 1'b1;
					else if (tbCount + 1'b1 == primaryReg)
						pinNext = 1'b0;
				end
				default:
					pinNext = 1'b0;
			endcase
		end
		else if (modeReg == `OCPP_MODE_OFF)
			pinNext = 1'b0;
		if (modeReg == `OCPP_MODE_PWMFLT && faultIn)
		begin
			faultSet = 1'b1;
			pinNext  = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers and state.
	always @(posedge clk)
	begin
		if (srst)
		begin
			modeReg      <= `OCPP_MODE_OFF;
			tbSelReg     <= 1'b0;
			run0Reg      <= 1'b0;
			run1Reg      <= 1'b0;
			irqEnReg     <= 1'b0;
			irqFlagReg   <= 1'b0;
			faultReg     <= 1'b0;
			armedReg     <= 1'b0;
			primaryReg   <= `OCPP_COUNT_ZERO;
			secondaryReg <= `OCPP_COUNT_ZERO;
			comparePin   <= 1'b0;
			irqReq       <= 1'b0;
		end
		else
		begin
			if (ctrlWr)
			begin
				modeReg  <= wrMode;
				tbSelReg <= regWdata[`OCPP_CTRL_TBSEL];
				run0Reg  <= regWdata[`OCPP_CTRL_RUN0];
				run1Reg  <= regWdata[`OCPP_CTRL_RUN1];
				irqEnReg <= regWdata[`OCPP_CTRL_IRQEN];
			end
			comparePin <= pinNext;
			armedReg   <= armedNext;
			// Set wins over a software clear in the same cycle.
			if (flagSet)
				irqFlagReg <= 1'b1;
			else if (regWr && regAddr == `OCPP_REG_STATUS && regWdata[`OCPP_STAT_IRQFLAG])
				irqFlagReg <= 1'b0;
			irqReq <= (irqFlagReg || flagSet) && irqEnReg;
			// hardware-only clear when fault mode is left.
			if (faultSet)
				faultReg <= 1'b1;
			else if (modeReg != `OCPP_MODE_PWMFLT)
				faultReg <= 1'b0;
			if (regWr && regAddr == `OCPP_REG_SECONDARY)
				secondaryReg <= regWdata;
			if (isPwm)
			begin
				if (perHit)
					primaryReg <= secondaryReg;
			end
			else if (regWr && regAddr == `OCPP_REG_PRIMARY)
				primaryReg <= regWdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port.
	always @*
	begin
		rdNext = {WIDTH{1'b0}};
		case (regAddr)
			`OCPP_REG_CTRL:
			begin
				rdNext[`OCPP_CTRL_MODE_HI:`OCPP_CTRL_MODE_LO] = modeReg;
				rdNext[`OCPP_CTRL_TBSEL] = tbSelReg;
				rdNext[`OCPP_CTRL_FAULT] = faultReg;
				rdNext[`OCPP_CTRL_RUN0]  = run0Reg;
				rdNext[`OCPP_CTRL_RUN1]  = run1Reg;
				rdNext[`OCPP_CTRL_IRQEN] = irqEnReg;
			end
			`OCPP_REG_PRIMARY:   rdNext = primaryReg;
			`OCPP_REG_SECONDARY: rdNext = secondaryReg;
			`OCPP_REG_PERIOD0:   rdNext = period0Reg;
			`OCPP_REG_PERIOD1:   rdNext = period1Reg;
			`OCPP_REG_TIMER0:    rdNext = timer0Reg;
			`OCPP_REG_TIMER1:    rdNext = timer1Reg;
			`OCPP_REG_STATUS:
			begin
				rdNext[`OCPP_STAT_IRQFLAG] = irqFlagReg;
				rdNext[`OCPP_STAT_PIN]     = comparePin;
				rdNext[`OCPP_STAT_FAULT]   = faultReg;
			end
			default: rdNext = {WIDTH{1'b0}};
		endcase
	end

	always @(posedge clk)
	begin
		if (srst)
			regRdata <= {WIDTH{1'b0}};
		else if (regRd)
			regRdata <= rdNext;
		else
			regRdata <= {WIDTH{1'b0}};
	end

endmodule

// file: design/ocpp_consts.vh
// Purpose: Constants for the output compare pulse and PWM channel.
// Assumes: Included by ocpp_channel.v only.
// Notes:   Register indices are word offsets on the plain register port.
`ifndef OCPP_CONSTS_VH
`define OCPP_CONSTS_VH

`define OCPP_REG_CTRL       3'h0
`define OCPP_REG_PRIMARY    3'h1
`define OCPP_REG_SECONDARY  3'h2
`define OCPP_REG_PERIOD0    3'h3
`define OCPP_REG_PERIOD1    3'h4
`define OCPP_REG_TIMER0     3'h5
`define OCPP_REG_TIMER1     3'h6
`define OCPP_REG_STATUS     3'h7

`define OCPP_CTRL_MODE_LO   0
`define OCPP_CTRL_MODE_HI   2
`define OCPP_CTRL_TBSEL     3
`define OCPP_CTRL_FAULT     4
`define OCPP_CTRL_RUN0      5
`define OCPP_CTRL_RUN1      6
`define OCPP_CTRL_IRQEN     7

`define OCPP_STAT_IRQFLAG   0
`define OCPP_STAT_PIN       1
`define OCPP_STAT_FAULT     2

`define OCPP_MODE_OFF       3'h0
`define OCPP_MODE_SINGLE    3'h4
`define OCPP_MODE_CONT      3'h5
`define OCPP_MODE_PWM       3'h6
`define OCPP_MODE_PWMFLT    3'h7

`define OCPP_COUNT_ZERO     16'h0000
`define OCPP_RESET_PERIOD   16'hFFFF

`endif

// file: verif/ocpp_pin_model.sv
// Purpose: Load on the compare pin that counts high cycles and rising edges.
// Assumes: Pin is sampled on the rising clock edge.
// Notes:   Counters restart while clr is high.
`timescale 1ns/10ps
module ocpp_pin_model
(
	input  wire        clk,         // Clock
	input  wire        clr,         // Restart counting
	input  wire        pin,         // Compare output pin
	output reg  [15:0] highCnt_reg, // Cycles seen high
	output reg  [15:0] riseCnt_reg  // Rising edges seen
);
	reg prevPin_reg = 1'b0;
	always @(posedge clk)
	begin
		prevPin_reg <= pin;
		highCnt_reg <= clr ? 16'h0000 : highCnt_reg + {15'h0000, pin};
		riseCnt_reg <= clr ? 16'h0000 : riseCnt_reg + {15'h0000, pin & ~prevPin_reg};
	end
endmodule

// file: verif/ocpp_channel_chk_chk.sv
// Purpose: Port checker for the compare channel.
// Assumes: Sees only the channel ports.
// Notes:   Mode and irq enable are tracked from control writes.
`timescale 1ns/10ps
module ocpp_channel_chk
#(
	parameter WIDTH = 16
)
(
	input wire             clk,        // Clock
	input wire             srst,       // Reset
	input wire [2:0]       regAddr,    // Index
	input wire [WIDTH-1:0] regWdata,   // Write data
	input wire             regWr,      // Write strobe
	input wire             regRd,      // Read strobe
	input wire [WIDTH-1:0] regRdata,   // Read data
	input wire             tickEn0,    // Tick 0
	input wire             tickEn1,    // Tick 1
	input wire             faultIn,    // Fault
	input wire             comparePin, // Pin
	input wire             irqReq      // Request
);
	reg  [2:0] mode_reg;
	reg        ien_reg;
	wire       ctrlWr = regWr && regAddr == 3'h0;
	always @(posedge clk)
	begin
		if (srst)
		begin
			mode_reg <= 3'h0;
			ien_reg  <= 1'b0;
		end
		else if (ctrlWr)
		begin
			mode_reg <= regWdata[2:0];
			ien_reg  <= regWdata[7];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_SINGLE_LOW: assert property (ctrlWr && regWdata[2:0] == 3'h4 |=> !comparePin)
		else $error("Pin not low after single arm.");
	AST_CONT_LOW: assert property (ctrlWr && regWdata[2:0] == 3'h5 |=> !comparePin)
		else $error("Pin not low after continuous arm.");
	AST_MODE_OFF: assert property (mode_reg == 3'h0 && $past(mode_reg) == 3'h0 |-> !comparePin)
		else $error("Pin high while disabled.");
	AST_FAULT: assert property (mode_reg == 3'h7 && faultIn |-> ##[1:2] !comparePin)
		else $error("Fault did not force pin low.");
	AST_IRQ_EN: assert property (!ien_reg && !$past(ien_reg) |-> !irqReq)
		else $error("Request while disabled.");
	AST_IRQ_RISE: assert property ($rose(irqReq) |-> $past(ien_reg))
		else $error("Request rose without cause.");
	AST_PIN_EVENT: assert property ($changed(comparePin) |-> $past(tickEn0 || tickEn1 || regWr || faultIn))
		else $error("Pin moved without cause.");
	AST_RD_ZERO: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("Read data outside read slot.");
	cover property (ctrlWr && regWdata[2:0] == 3'h6);
	cover property ($rose(irqReq));
	cover property (mode_reg == 3'h7 && faultIn);
endmodule
bind ocpp_channel ocpp_channel_chk #(.WIDTH(WIDTH)) chk (.clk(clk), .srst(srst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.tickEn0(tickEn0), .tickEn1(tickEn1), .faultIn(faultIn), .comparePin(comparePin),
	.irqReq(irqReq));

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the compare channel.
// Assumes: Timer ticks every cycle while enabled.
// Notes:   Pulse shapes are judged over whole periods by the pin model.
`timescale 1ns/10ps
module tb_top;
	reg         clk, srst, regWr, regRd, tickEn0, tickEn1, faultIn, clr;
	reg  [2:0]  regAddr;
	reg  [15:0] regWdata;
	wire [15:0] regRdata, highCnt, riseCnt;
	wire        comparePin, irqReq;
	integer     error_cnt = 0;
	integer     comparisons = 0;
	ocpp_channel #(.WIDTH(16)) dut (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.tickEn0(tickEn0), .tickEn1(tickEn1), .faultIn(faultIn),
		.comparePin(comparePin), .irqReq(irqReq));
	ocpp_pin_model pm (.clk(clk), .clr(clr), .pin(comparePin), .highCnt_reg(highCnt),
		.riseCnt_reg(riseCnt));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task chk(input [15:0] got, input [15:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task tk(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task wr(input [2:0] a, input [15:0] d);
	begin
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	end
	endtask
	task rd(input [2:0] a, input [15:0] m, input [15:0] e);
	begin
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		// Read data stands only in the cycle after the read edge.
		#1;
		chk(regRdata & m, e);
	end
	endtask
	task meas(input integer n, input [15:0] h, input [15:0] r);
	begin
		clr <= 1'b1;
		tk(1);
		clr <= 1'b0;
		tk(n);
		chk(highCnt, h);
		chk(riseCnt, r);
	end
	endtask
	task duty(input [15:0] v, input [15:0] h, input [15:0] r);
	begin
		wr(3'h2, v);
		tk(14);
		meas(24, h, r);
	end
	endtask
	task results;
	begin
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#100000;
		error_cnt = error_cnt + 1;
		results;
	end
	initial
	begin
		srst = 1'b1;
		{regWr, regRd, faultIn, clr} = 4'h0;
		{tickEn0, tickEn1} = 2'h3;
		regAddr = 3'h0;
		regWdata = 16'h0000;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(3'h3, 16'hFFFF, 16'hFFFF);
		rd(3'h7, 16'hFFFF, 16'h0000);
		wr(3'h1, 16'h0005);
		wr(3'h2, 16'h0008);
		wr(3'h3, 16'h000B);
		wr(3'h0, 16'h00A4);
		meas(48, 3, 1);
		rd(3'h7, 16'h0003, 16'h0001);
		chk(irqReq, 1);
		wr(3'h7, 16'h0001);
		tk(1);
		chk(irqReq, 0);
		wr(3'h5, 16'h0000);
		wr(3'h0, 16'h00A4);
		meas(48, 3, 1);
		wr(3'h5, 16'h0000);
		wr(3'h0, 16'h0025);
		meas(48, 12, 4);
		rd(3'h7, 16'h0001, 16'h0001);
		wr(3'h2, 16'h0004);
		wr(3'h1, 16'h0004);
		wr(3'h5, 16'h0000);
		wr(3'h0, 16'h0026);
		meas(48, 16, 4);
		wr(3'h1, 16'h0007);
		rd(3'h1, 16'hFFFF, 16'h0004);
		duty(16'h0000, 0, 0);
		duty(16'h000C, 24, 0);
		duty(16'h000B, 22, 2);
		rd(3'h1, 16'hFFFF, 16'h000B);
		wr(3'h0, 16'h00A7);
		faultIn <= 1'b1;
		tk(4);
		rd(3'h7, 16'h0006, 16'h0004);
		faultIn <= 1'b0;
		wr(3'h0, 16'h0000);
		chk(comparePin, 0);
		wr(3'h4, 16'h0009);
		wr(3'h1, 16'h0002);
		wr(3'h2, 16'h0005);
		wr(3'h6, 16'h0000);
		wr(3'h0, 16'h004D);
		meas(40, 12, 4);
		results;
	end
endmodule
